// ### hw/cps_pkg.sv
// Package: register map, bit positions and carrier types of the charger port status bank
package cps_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CPS_ADDR_GENERAL_STATUS = 8'h11;
    localparam logic [7:0] CPS_ADDR_PROFILE_STATUS_FIRST = 8'h12;
    localparam logic [7:0] CPS_ADDR_PROFILE_STATUS_SECOND = 8'h13;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CPS_GEN_QUOTA_BIT = 7;
    localparam int CPS_GEN_CC_BIT = 4;
    localparam int CPS_GEN_THERMAL_REGULATION_FLAG_BIT = 3;
    localparam int CPS_GEN_LOW_CURRENT_FLAG_BIT = 2;
    localparam int CPS_GEN_REMOVAL_BIT = 1;
    localparam int CPS_GEN_ATTACH_BIT = 0;
    localparam int CPS_P1_NO_HANDSHAKE_FLAG_BIT = 7;
    localparam int CPS_P1_SOURCE_UNDERVOLTAGE_FLAG_BIT = 4;
    localparam int CPS_P1_CUSTOM_BIT = 3;
    localparam int CPS_P1_DCP_BIT = 2;
    localparam int CPS_P1_CDP_BIT = 1;
    localparam int CPS_P1_PT_BIT = 0;

    // Index into the clear-on-read flag vector
    localparam int CPS_COR_WIDTH = 5;
    localparam int CPS_COR_QUOTA = 4;
    localparam int CPS_COR_THERMAL_REGULATION_FLAG = 3;
    localparam int CPS_COR_LOW_CURRENT_FLAG = 2;
    localparam int CPS_COR_REMOVAL = 1;
    localparam int CPS_COR_ATTACH = 0;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0] CPS_STATUS_RESET = 8'h00;
    localparam logic [6:0] CPS_LEGACY_RESET = 7'h00;
    localparam logic [4:0] CPS_COR_RESET = 5'h00;
    localparam logic [1:0] CPS_QUOTA_REPORT = 2'h0;
    localparam logic [1:0] CPS_QUOTA_REPORT_DISCONNECT = 2'h1;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cps_req_t;

    typedef struct packed {
        logic quota_reached;
        logic thermal_regulation_flag;
        logic low_current_flag;
        logic removal;
        logic attach;
        logic cc_region;
        logic vs_uvlo;
        logic custom_ok;
        logic dcp_ok;
        logic cdp_ok;
        logic pt_mode;
        logic no_handshake_flag;
        logic new_profile;
        logic [6:0] legacy_ok;
    } cps_evt_t;

    typedef struct packed {
        logic [1:0] quota_action_select;
        logic quota_counter_clear;
        logic quota_enable;
        logic alert_link;
        logic port_power_enable;
        logic mode_select_first;
        logic mode_change;
        logic dedicated_charge_cycle;
        logic hs_switch_charge_ctrl;
        logic custom_hs_closed;
        logic custom_trip_limit;
    } cps_cfg_t;

    typedef struct packed {
        logic [4:0] flags;
    } cps_cor_state_t;

    typedef struct packed {
        logic [7:0] rd_data;
        logic alert_n;
        logic attach_detect_n;
        logic no_handshake_flag;
        logic custom;
        logic dcp;
        logic cdp;
        logic pt;
        logic pt_armed;
        logic m1_prev;
        logic [6:0] legacy;
        logic hs_closed;
        logic trip_limit;
        logic hold_off;
    } cps_state_t;

endpackage

// ### hw/cps_cor_flags.sv
// Clear-on-read sticky flags of the general status register
`timescale 1ns/100ps
`default_nettype none
module cps_cor_flags (
    input wire logic clk,
    input wire logic rst,
    input wire logic [cps_pkg::CPS_COR_WIDTH-1:0] set,
    input wire logic rd_clr,
    input wire logic [cps_pkg::CPS_COR_WIDTH-1:0] hw_clr,
    output logic [cps_pkg::CPS_COR_WIDTH-1:0] flags
);
    import cps_pkg::*;

    cps_cor_state_t s_q;
    cps_cor_state_t s_d;

    // Control clears win; a read never swallows a same-cycle event
    always_comb begin
        s_d = s_q;
        for (int i = 0; i < CPS_COR_WIDTH; i++) begin
            s_d.flags[i] = !hw_clr[i] && (set[i] || (s_q.flags[i] && !rd_clr)); // RULE20
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '{flags: CPS_COR_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign flags = s_q.flags;

endmodule
`default_nettype wire

// ### hw/cps_status_regs.sv
// Status register bank: general status and two profile status registers
//
// Notes on behaviour
// [RULE1] Quota flag sets; alerts host when action notifies
// [RULE2] Quota flag cleared by read, clear, disable
// [RULE3] Constant current bit is live region indication
// [RULE4] Thermal flag sticky; alerts only with link set
// [RULE5] Low current flag sticky; alerts only if linked
// [RULE6] Removal sets flag, releases attach detect
// [RULE7] Attach sets flag, asserts attach detect
// [RULE8] First profile bits never touch the alert or attach detect pins
// [RULE9] Profile flags clear on power off, mode, removal
// [RULE10] No handshake flag only in dedicated cycle
// [RULE11] Undervoltage bit live, holds power switch off
// [RULE12] Custom flag; switch and limit from custom
// [RULE13] DCP flag; switch from control, constant current
// [RULE14] CDP flag; switch closed, trip limiting
// [RULE15] Pass-through flag; switch closed, trip limiting
// [RULE16] Pass-through rearms only after mode toggle
// [RULE17] Legacy 3-7 flags set on accepted handshake
// [RULE18] Second profile register clears like first
// [RULE19] Legacy 1-2 flags set likewise
// [RULE20] Read clears flag unless same-cycle event
// [RULE21] Unused bits read zero; writes ignored
`timescale 1ns/100ps
`default_nettype none
module cps_status_regs (
    input wire logic clk,
    input wire logic rst,
    input wire cps_pkg::cps_req_t req,
    input wire cps_pkg::cps_evt_t evt,
    input wire cps_pkg::cps_cfg_t cfg,
    output logic [7:0] rd_data,
    output logic alert_n,
    output logic attach_detect_out_n,
    output logic hs_switch_closed,
    output logic trip_limit_mode,
    output logic port_switch_hold_off
);
    import cps_pkg::*;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    logic rd_gen;
    logic [4:0] cor_set;
    logic [4:0] cor_hw_clr;
    logic [4:0] cor_q;
    logic prof_clr;
    logic quota_notify;

    assign rd_gen = req.rd_en && (req.addr == CPS_ADDR_GENERAL_STATUS); // RULE20
    assign cor_set = {evt.quota_reached, evt.thermal_regulation_flag, evt.low_current_flag, evt.removal, evt.attach}; // RULE4 RULE5
    // Only the quota flag has clears other than a read
    assign cor_hw_clr = {cfg.quota_counter_clear || !cfg.quota_enable, 4'h0}; // RULE2
    assign prof_clr = !cfg.port_power_enable || cfg.mode_change || evt.removal; // RULE9 RULE18
    assign quota_notify = (cfg.quota_action_select == CPS_QUOTA_REPORT)
        || (cfg.quota_action_select == CPS_QUOTA_REPORT_DISCONNECT);

    cps_cor_flags u_cor (
        .clk(clk),
        .rst(rst),
        .set(cor_set),
        .rd_clr(rd_gen),
        .hw_clr(cor_hw_clr),
        .flags(cor_q)
    );

    cps_state_t s_q;
    cps_state_t s_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Read data; writes to these registers are simply dropped
        s_d.rd_data = 8'h00; // RULE21
        if (req.rd_en) begin
            case (req.addr)
                CPS_ADDR_GENERAL_STATUS: begin
                    s_d.rd_data[CPS_GEN_QUOTA_BIT] = cor_q[CPS_COR_QUOTA];
                    s_d.rd_data[CPS_GEN_CC_BIT] = evt.cc_region; // RULE3
                    s_d.rd_data[CPS_GEN_THERMAL_REGULATION_FLAG_BIT] = cor_q[CPS_COR_THERMAL_REGULATION_FLAG];
                    s_d.rd_data[CPS_GEN_LOW_CURRENT_FLAG_BIT] = cor_q[CPS_COR_LOW_CURRENT_FLAG];
                    s_d.rd_data[CPS_GEN_REMOVAL_BIT] = cor_q[CPS_COR_REMOVAL];
                    s_d.rd_data[CPS_GEN_ATTACH_BIT] = cor_q[CPS_COR_ATTACH];
                end
                CPS_ADDR_PROFILE_STATUS_FIRST: begin
                    s_d.rd_data[CPS_P1_NO_HANDSHAKE_FLAG_BIT] = s_q.no_handshake_flag;
                    s_d.rd_data[CPS_P1_SOURCE_UNDERVOLTAGE_FLAG_BIT] = evt.vs_uvlo; // RULE11
                    s_d.rd_data[CPS_P1_CUSTOM_BIT] = s_q.custom;
                    s_d.rd_data[CPS_P1_DCP_BIT] = s_q.dcp;
                    s_d.rd_data[CPS_P1_CDP_BIT] = s_q.cdp;
                    s_d.rd_data[CPS_P1_PT_BIT] = s_q.pt;
                end
                CPS_ADDR_PROFILE_STATUS_SECOND: begin
                    s_d.rd_data = {1'b0, s_q.legacy};
                end
                default: begin
                    s_d.rd_data = CPS_STATUS_RESET;
                end
            endcase
        end

        // Alert pin follows only the general status flags; attach detect follows the attach and removal events
        s_d.alert_n = !((cor_q[CPS_COR_QUOTA] && quota_notify) // RULE1
            || (cfg.alert_link && (cor_q[CPS_COR_THERMAL_REGULATION_FLAG] || cor_q[CPS_COR_LOW_CURRENT_FLAG]))); // RULE4 RULE5 RULE8
        if (evt.attach) begin
            s_d.attach_detect_n = 1'b0; // RULE7
        end else if (evt.removal) begin
            s_d.attach_detect_n = 1'b1; // RULE6
        end

        // Pass-through rearm on a toggle of the first mode select
        s_d.m1_prev = cfg.mode_select_first;
        if ((cfg.mode_select_first != s_q.m1_prev) || cfg.mode_change) begin
            s_d.pt_armed = 1'b1; // RULE16
        end else if (evt.removal) begin
            s_d.pt_armed = 1'b0; // RULE16
        end

        // Profile flags; a clear condition outranks a same-cycle accept
        if (prof_clr) begin
            s_d.custom = 1'b0; // RULE9
            s_d.dcp = 1'b0;
            s_d.cdp = 1'b0;
            s_d.pt = 1'b0;
            s_d.legacy = CPS_LEGACY_RESET; // RULE18
        end else begin
            s_d.custom = s_q.custom || evt.custom_ok; // RULE12
            s_d.dcp = s_q.dcp || evt.dcp_ok; // RULE13
            s_d.cdp = s_q.cdp || evt.cdp_ok; // RULE14
            s_d.pt = s_q.pt || (evt.pt_mode && s_q.pt_armed); // RULE15 RULE16
            s_d.legacy = s_q.legacy | evt.legacy_ok; // RULE17 RULE19
        end

        // Any accepted profile drops it too, so it never stands beside one
        if (evt.new_profile || !cfg.dedicated_charge_cycle
            || s_d.custom || s_d.dcp || s_d.cdp || s_d.pt || (|s_d.legacy)) begin
            s_d.no_handshake_flag = 1'b0; // RULE10
        end else if (evt.no_handshake_flag) begin
            s_d.no_handshake_flag = 1'b1; // RULE10
        end

        // Switch and limit mode from the accepted profile
        s_d.hs_closed = 1'b0;
        s_d.trip_limit = 1'b0;
        if (s_q.cdp || s_q.pt) begin
            s_d.hs_closed = 1'b1; // RULE14 RULE15
            s_d.trip_limit = 1'b1;
        end else if (s_q.dcp) begin
            s_d.hs_closed = cfg.hs_switch_charge_ctrl; // RULE13
        end else if (s_q.custom) begin
            s_d.hs_closed = cfg.custom_hs_closed; // RULE12
            s_d.trip_limit = cfg.custom_trip_limit;
        end else if (|s_q.legacy) begin
            s_d.hs_closed = cfg.hs_switch_charge_ctrl; // RULE17 RULE19
            s_d.trip_limit = cfg.custom_trip_limit;
        end
        s_d.hold_off = evt.vs_uvlo; // RULE11
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '{rd_data: CPS_STATUS_RESET, alert_n: 1'b1, attach_detect_n: 1'b1,
                     no_handshake_flag: 1'b0, custom: 1'b0, dcp: 1'b0, cdp: 1'b0, pt: 1'b0,
                     pt_armed: 1'b1, m1_prev: 1'b0, legacy: CPS_LEGACY_RESET,
                     hs_closed: 1'b0, trip_limit: 1'b0, hold_off: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd_data;
    assign alert_n = s_q.alert_n;
    assign attach_detect_out_n = s_q.attach_detect_n;
    assign hs_switch_closed = s_q.hs_closed;
    assign trip_limit_mode = s_q.trip_limit;
    assign port_switch_hold_off = s_q.hold_off;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_quota_hit;
        evt.quota_reached && quota_notify && cfg.quota_enable && !cfg.quota_counter_clear;
    endsequence
    sequence s_quota_held;
        cfg.quota_enable && !cfg.quota_counter_clear && !rd_gen && quota_notify;
    endsequence

    property p_quota_alert;
        s_quota_hit ##1 s_quota_held |=> !alert_n;
    endproperty
    a_quota_alert: assert property (p_quota_alert) else $error("quota flag did not alert"); // RULE1

    property p_quota_clear;
        cfg.quota_counter_clear |=> !cor_q[CPS_COR_QUOTA];
    endproperty
    a_quota_clear: assert property (p_quota_clear) else $error("quota clear ignored"); // RULE2

    property p_cc_live;
        rd_gen |=> rd_data[CPS_GEN_CC_BIT] == $past(evt.cc_region);
    endproperty
    a_cc_live: assert property (p_cc_live) else $error("region bit not live"); // RULE3

    property p_thermal_regulation_flag_unlinked;
        !cfg.alert_link && !cor_q[CPS_COR_QUOTA] |=> alert_n;
    endproperty
    a_thermal_regulation_flag_unlinked: assert property (p_thermal_regulation_flag_unlinked) else $error("alert without cause"); // RULE4

    property p_low_current_flag_linked;
        evt.low_current_flag && cfg.alert_link ##1 cfg.alert_link |=> !alert_n;
    endproperty
    a_low_current_flag_linked: assert property (p_low_current_flag_linked) else $error("linked low current no alert"); // RULE5

    property p_removal;
        evt.removal && !evt.attach |=> cor_q[CPS_COR_REMOVAL] && attach_detect_out_n;
    endproperty
    a_removal: assert property (p_removal) else $error("removal not reported"); // RULE6

    property p_attach;
        evt.attach |=> cor_q[CPS_COR_ATTACH] && !attach_detect_out_n;
    endproperty
    a_attach: assert property (p_attach) else $error("attach not reported"); // RULE7

    property p_read_race;
        rd_gen && evt.thermal_regulation_flag |=> cor_q[CPS_COR_THERMAL_REGULATION_FLAG];
    endproperty
    a_read_race: assert property (p_read_race) else $error("event lost to read"); // RULE20

    property p_read_clears;
        rd_gen && !evt.low_current_flag |=> !cor_q[CPS_COR_LOW_CURRENT_FLAG];
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // RULE20

    property p_profile_clear;
        !cfg.port_power_enable |=> !(s_q.custom || s_q.dcp || s_q.cdp || s_q.pt) && s_q.legacy == 7'h00;
    endproperty
    a_profile_clear: assert property (p_profile_clear) else $error("profiles not cleared"); // RULE9 RULE18

    property p_no_handshake_flag_alone;
        s_q.no_handshake_flag |-> !(s_q.custom || s_q.dcp || s_q.cdp || s_q.pt || (|s_q.legacy));
    endproperty
    a_no_handshake_flag_alone: assert property (p_no_handshake_flag_alone) else $error("no handshake with profile"); // RULE10

    property p_cdp_switch;
        s_q.cdp |=> hs_switch_closed && trip_limit_mode;
    endproperty
    a_cdp_switch: assert property (p_cdp_switch) else $error("cdp switch wrong"); // RULE14

    property p_pt_rearm;
        evt.removal && !cfg.mode_change && cfg.mode_select_first == s_q.m1_prev
            ##1 cfg.mode_select_first == s_q.m1_prev && !cfg.mode_change |=> !s_q.pt;
    endproperty
    a_pt_rearm: assert property (p_pt_rearm) else $error("pass-through set without toggle"); // RULE16

    property p_unused_zero;
        req.rd_en && (req.addr != CPS_ADDR_PROFILE_STATUS_SECOND) |=> rd_data[6:5] == 2'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero"); // RULE21

    property p_second_top_zero;
        req.rd_en && (req.addr == CPS_ADDR_PROFILE_STATUS_SECOND) |=> !rd_data[7];
    endproperty
    a_second_top_zero: assert property (p_second_top_zero) else $error("second profile top bit set"); // RULE21

    property p_detect_pin_quiet;
        !evt.attach && !evt.removal |=> $stable(attach_detect_out_n);
    endproperty
    a_detect_pin_quiet: assert property (p_detect_pin_quiet) else $error("detect pin moved without event"); // RULE8

    property p_uvlo_hold;
        evt.vs_uvlo |=> port_switch_hold_off;
    endproperty
    a_uvlo_hold: assert property (p_uvlo_hold) else $error("switch not held off"); // RULE11

    property p_dcp_switch;
        s_q.dcp && !s_q.cdp && !s_q.pt
            |=> hs_switch_closed == $past(cfg.hs_switch_charge_ctrl) && !trip_limit_mode;
    endproperty
    a_dcp_switch: assert property (p_dcp_switch) else $error("dcp switch wrong"); // RULE13

    property p_pt_switch;
        s_q.pt |=> hs_switch_closed && trip_limit_mode;
    endproperty
    a_pt_switch: assert property (p_pt_switch) else $error("pass-through switch wrong"); // RULE15

    property p_custom_switch;
        s_q.custom && !(s_q.cdp || s_q.pt || s_q.dcp)
            |=> hs_switch_closed == $past(cfg.custom_hs_closed) && trip_limit_mode == $past(cfg.custom_trip_limit);
    endproperty
    a_custom_switch: assert property (p_custom_switch) else $error("custom switch wrong"); // RULE12

    property p_legacy_set;
        !prof_clr && (|evt.legacy_ok) |=> (s_q.legacy & $past(evt.legacy_ok)) == $past(evt.legacy_ok);
    endproperty
    a_legacy_set: assert property (p_legacy_set) else $error("legacy accept lost"); // RULE17 RULE19

    property p_mode_clear;
        cfg.mode_change || evt.removal |=> !(s_q.custom || s_q.dcp || s_q.cdp || s_q.pt) && s_q.legacy == 7'h00;
    endproperty
    a_mode_clear: assert property (p_mode_clear) else $error("profiles kept over mode or removal"); // RULE9 RULE18

endmodule
`default_nettype wire

// ### tb/cps_host_model.sv
// Host controller model that issues register reads and writes
`timescale 1ns/100ps
`default_nettype none
module cps_host_model (
    input wire logic clk,
    input wire logic rst,
    output var cps_pkg::cps_req_t req
);
    import cps_pkg::*;

    initial req = '0;

    // ------------------------------------------------------------
    // Access task
    // ------------------------------------------------------------
    // Strobe goes up just after an edge and is held across one taking edge
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data, input int gap);
        repeat (gap) begin
            @(posedge clk);
            #1;
        end
        while (rst) begin
            @(posedge clk);
            #1;
        end
        req = '{rd_en: !wr, wr_en: wr, addr: addr, wdata: data};
        @(posedge clk);
        #1;
        req = '0;
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the charger port status register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import cps_pkg::*;
    localparam logic [7:0] GEN = CPS_ADDR_GENERAL_STATUS;
    localparam logic [7:0] P1 = CPS_ADDR_PROFILE_STATUS_FIRST;
    localparam logic [7:0] P2 = CPS_ADDR_PROFILE_STATUS_SECOND;
    logic clk = 1'b0;
    logic rst = 1'b1;
    cps_req_t req;
    cps_evt_t evt = '0;
    cps_cfg_t cfg = '{port_power_enable: 1'b1, default: '0};
    logic [7:0] rd_data;
    logic alert_n, attach_detect_out_n, hs_switch_closed, trip_limit_mode, port_switch_hold_off;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h594EB9F4;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    always #50 clk = ~clk;

    cps_host_model host_u (.clk(clk), .rst(rst), .req(req));
    cps_status_regs dut_u (.clk(clk), .rst(rst), .req(req), .evt(evt), .cfg(cfg), .rd_data(rd_data),
        .alert_n(alert_n), .attach_detect_out_n(attach_detect_out_n), .hs_switch_closed(hs_switch_closed),
        .trip_limit_mode(trip_limit_mode), .port_switch_hold_off(port_switch_hold_off));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic print_verdict();
        if (exp_q.size() != 0) begin
            miscompares++;
            $display("BAD %0t reads left unanswered", $time);
        end
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        total_checks++;
        if (got !== e) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, e);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic pin(input logic got, input logic e);
        chk({7'h00, got}, {7'h00, e});
    endtask

    // Random gap of one or two cycles so the host is sometimes slow
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        seed = lfsr_next(seed);
        exp_q.push_back(e);
        host_u.access(1'b0, a, 8'h00, 1 + seed[0]);
    endtask

    task automatic pulse(input cps_evt_t p);
        evt = evt | p;
        tick(1);
        evt = evt & ~p;
        tick(2);
    endtask

    task automatic mode_pulse();
        cfg.mode_change = 1'b1;
        tick(1);
        cfg.mode_change = 1'b0;
        tick(1);
    endtask

    // ------------------------------------------------------------
    // Read-data watcher and hang guard
    // ------------------------------------------------------------
    always @(posedge clk) begin
        rd_seen <= req.rd_en;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            $display("BAD %0t run did not finish in time", $time);
            print_verdict();
        end
    end

    always @(negedge clk) begin
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("BAD %0t read data without a pending read", $time);
            end else begin
                chk(rd_data, exp_q.pop_front());
            end
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        tick(6);
        rst = 1'b0;
        rd(GEN, 8'h00);
        rd(P1, 8'h00);
        rd(P2, 8'h00);
        pin(alert_n, 1'b1);
        pin(attach_detect_out_n, 1'b1);
        pulse('{attach: 1'b1, default: '0});
        pin(attach_detect_out_n, 1'b0);
        pin(alert_n, 1'b1);
        rd(GEN, 8'h01);
        rd(GEN, 8'h00);
        pulse('{removal: 1'b1, default: '0});
        pin(attach_detect_out_n, 1'b1);
        pin(alert_n, 1'b1);
        rd(GEN, 8'h02);
        tick(1);
        // Event lands in the very cycle of the read that would clear it
        evt.attach = 1'b1;
        exp_q.push_back(8'h00);
        host_u.access(1'b0, GEN, 8'h00, 0);
        evt.attach = 1'b0;
        rd(GEN, 8'h01);
        for (int k = 0; k < 2; k++) begin
            cfg.alert_link = k[0];
            pulse('{thermal_regulation_flag: 1'b1, default: '0});
            pin(alert_n, !k[0]);
            rd(GEN, 8'h08);
            pulse('{low_current_flag: 1'b1, default: '0});
            pin(alert_n, !k[0]);
            rd(GEN, 8'h04);
        end
        cfg.alert_link = 1'b0;
        cfg.quota_enable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            cfg.quota_action_select = k[1:0];
            pulse('{quota_reached: 1'b1, default: '0});
            pin(alert_n, k[1]);
            rd(GEN, 8'h80);
        end
        pulse('{quota_reached: 1'b1, default: '0});
        cfg.quota_counter_clear = 1'b1;
        tick(1);
        cfg.quota_counter_clear = 1'b0;
        rd(GEN, 8'h00);
        pulse('{quota_reached: 1'b1, default: '0});
        cfg.quota_enable = 1'b0;
        tick(1);
        rd(GEN, 8'h00);
        evt.cc_region = 1'b1;
        tick(1);
        rd(GEN, 8'h10);
        evt.cc_region = 1'b0;
        tick(1);
        rd(GEN, 8'h00);
        evt.vs_uvlo = 1'b1;
        tick(2);
        pin(port_switch_hold_off, 1'b1);
        rd(P1, 8'h10);
        evt.vs_uvlo = 1'b0;
        tick(2);
        pin(port_switch_hold_off, 1'b0);
        rd(P1, 8'h00);
        pulse('{cdp_ok: 1'b1, default: '0});
        pin(hs_switch_closed, 1'b1);
        pin(trip_limit_mode, 1'b1);
        pin(attach_detect_out_n, 1'b0);
        pin(alert_n, 1'b1);
        rd(P1, 8'h02);
        pulse('{removal: 1'b1, default: '0});
        rd(P1, 8'h00);
        rd(GEN, 8'h02);
        cfg.hs_switch_charge_ctrl = 1'b1;
        pulse('{dcp_ok: 1'b1, default: '0});
        pin(hs_switch_closed, 1'b1);
        pin(trip_limit_mode, 1'b0);
        rd(P1, 8'h04);
        mode_pulse();
        rd(P1, 8'h00);
        cfg.custom_trip_limit = 1'b1;
        cfg.custom_hs_closed = 1'b1;
        cfg.hs_switch_charge_ctrl = 1'b0;
        pulse('{custom_ok: 1'b1, default: '0});
        pin(hs_switch_closed, 1'b1);
        pin(trip_limit_mode, 1'b1);
        rd(P1, 8'h08);
        cfg.port_power_enable = 1'b0;
        tick(1);
        rd(P1, 8'h00);
        cfg.port_power_enable = 1'b1;
        cfg.custom_trip_limit = 1'b0;
        for (int i = 0; i < 7; i++) begin
            cfg.hs_switch_charge_ctrl = i[0];
            pulse('{legacy_ok: 7'(1 << i), default: '0});
            pin(hs_switch_closed, i[0]);
            pin(trip_limit_mode, 1'b0);
            rd(P2, 8'(1 << i));
            mode_pulse();
            rd(P2, 8'h00);
        end
        cfg.dedicated_charge_cycle = 1'b1;
        pulse('{no_handshake_flag: 1'b1, default: '0});
        rd(P1, 8'h80);
        pulse('{custom_ok: 1'b1, default: '0});
        rd(P1, 8'h08);
        mode_pulse();
        pulse('{no_handshake_flag: 1'b1, default: '0});
        rd(P1, 8'h80);
        pulse('{new_profile: 1'b1, default: '0});
        rd(P1, 8'h00);
        cfg.dedicated_charge_cycle = 1'b0;
        pulse('{no_handshake_flag: 1'b1, default: '0});
        rd(P1, 8'h00);
        evt.pt_mode = 1'b1;
        tick(2);
        pin(hs_switch_closed, 1'b1);
        pin(trip_limit_mode, 1'b1);
        rd(P1, 8'h01);
        pulse('{removal: 1'b1, default: '0});
        pulse('{attach: 1'b1, default: '0});
        rd(P1, 8'h00);
        cfg.mode_select_first = 1'b1;
        tick(2);
        rd(P1, 8'h01);
        rd(GEN, 8'h03);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr_next(seed);
            host_u.access(1'b1, GEN + 8'(k), seed[7:0], 1);
            rd(GEN + 8'(k), (k == 1) ? 8'h01 : 8'h00);
        end
        rd(8'h14, 8'h00);
        rd(8'h10, 8'h00);
        tick(3);
        print_verdict();
    end
endmodule
`default_nettype wire
